//--- sopid_pkg.sv
// system options and part number register bank: shared constants and types
// assumes an 8-bit register port with word indexes and a single 125 MHz clock
package sopid_pkg;

   // register indexes on the plain register port
   localparam logic [2:0] SOPID_IDX_OPT1 = 3'h0;
   localparam logic [2:0] SOPID_IDX_OPT2 = 3'h1;
   localparam logic [2:0] SOPID_IDX_IDH = 3'h2;
   localparam logic [2:0] SOPID_IDX_IDL = 3'h3;
   localparam logic [2:0] SOPID_IDX_SVC = 3'h4;

   // first option register fields
   localparam int SOPID_O1_TOUT_HI = 7;
   localparam int SOPID_O1_TOUT_LO = 6;
   localparam int SOPID_O1_STOP = 5;
   localparam int SOPID_O1_TWOW = 2;
   localparam logic [7:0] SOPID_O1_MASK = 8'hE4;
   localparam logic [7:0] SOPID_O1_RST = 8'h00;

   // second option register fields
   localparam int SOPID_O2_CLKS = 7;
   localparam int SOPID_O2_WIN = 6;
   localparam int SOPID_O2_CAPR = 4;
   localparam int SOPID_O2_T2C1 = 3;
   localparam int SOPID_O2_T2C0 = 2;
   localparam int SOPID_O2_T1C1 = 1;
   localparam int SOPID_O2_T1C0 = 0;
   localparam logic [7:0] SOPID_O2_ONCE = 8'hC0;
   localparam logic [7:0] SOPID_O2_FREE = 8'h1F;
   localparam logic [7:0] SOPID_O2_RST = 8'h00;

   // part number high register layout
   localparam int SOPID_IDH_FAMILY = 7;
   localparam logic [3:0] SOPID_IDH_RSVD = 4'h0;

   // service sequence bytes
   localparam logic [7:0] SOPID_SVC_FIRST = 8'h55;
   localparam logic [7:0] SOPID_SVC_SECOND = 8'hAA;

   localparam logic [7:0] SOPID_RDATA_RST = 8'h00;

   // watchdog sequence tracker, one-hot
   typedef enum logic [1:0] {
      SOPID_SVC_IDLE = 2'b01,
      SOPID_SVC_ARMED = 2'b10
   } sopid_svc_t;

   // alternate pin placement selects
   typedef struct packed {
      logic iic_on_port_b;
      logic tim2_ch1_on_pa7;
      logic tim2_ch0_on_pa6;
      logic tim1_ch1_on_pc1;
      logic tim1_ch0_on_pc0;
   } sopid_route_t;

   // watchdog and stop configuration seen by the rest of the chip
   typedef struct packed {
      logic [1:0] timeout_sel;
      logic use_bus_clk;
      logic window_on;
      logic stop_permit;
   } sopid_wdog_cfg_t;

endpackage

//--- sopid_regs.sv
// system options and part number register bank with watchdog service decode
// assumes one 125 MHz clock, a plain register port and a watchdog counter
// outside that reports its enable and whether it sits in the last quarter
//
// Functional notes
// - first option register: first write only
// - bits 7:6 plus clock select pick timeout
// - stop permit once; cleared makes stop illegal
// - bit 2 moves two-wire pins to port B
// - clock select once: 0 slow, 1 bus
// - window mode: early service write resets
// - window bit once, only with bus clock
// - bit 4 routes comparator to capture input
// - bit 3 moves timer2 channel 1 pin
// - bit 2 moves timer2 channel 0 pin
// - bit 1 moves timer1 channel 1 pin
// - bit 0 moves timer1 channel 0 pin
// - family marker bit 7 reads one
// - reserved id bits ignore writes
// - fixed 12-bit part number, read only
// - 0x55 then 0xAA clears; lone 0xAA ignored; other bytes reset if enabled

`timescale 1ns/1ps

module sopid_regs
   import sopid_pkg::*;
#(
   parameter logic [11:0] PART_NUMBER = 12'h5C3 // arbitrary value
)
(
   input wire logic i_ref_clk, // 125 MHz clock
   input wire logic i_rst_n, // synchronous reset, low
   input wire logic [2:0] i_addr, // register index
   input wire logic [7:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [7:0] o_rdata, // read data, cycle after strobe
   input wire logic i_wdog_enabled, // watchdog running
   input wire logic i_wdog_late, // counter in last quarter
   input wire logic i_stop_req, // cpu executes stop
   input wire logic i_cmp_out, // analog comparator output
   output sopid_wdog_cfg_t o_wdog_cfg, // watchdog configuration
   output sopid_route_t o_route, // pin placement selects
   output logic o_cap_route_en, // comparator drives capture
   output logic o_tim1_ch0_cmp, // comparator level to capture
   output logic o_wdog_clear, // pulse: clear counter
   output logic o_wdog_reset, // pulse: watchdog reset
   output logic o_stop_enter, // pulse: enter stop
   output logic o_illegal_reset // pulse: illegal opcode reset
);

   logic [7:0] opt1_reg;
   logic [7:0] opt2_reg;
   logic opt1_lock_reg;
   logic opt2_lock_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   sopid_svc_t svc_reg;
   logic clear_reg;
   logic wreset_reg;
   logic stop_reg;
   logic illegal_reg;
   logic cmp_meta_reg;
   logic cmp_sync_reg;
   logic cap_reg;
   logic wr_opt1;
   logic wr_opt2;
   logic wr_svc;
   logic window_on;
   logic early_hit;

   // read decode for the read data mux
   function automatic logic [7:0] read_mux(input logic [2:0] idx, input logic [7:0] o1,
                                           input logic [7:0] o2);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         SOPID_IDX_OPT1: v = o1 & SOPID_O1_MASK;
         SOPID_IDX_OPT2: v = o2 & (SOPID_O2_ONCE | SOPID_O2_FREE);
         SOPID_IDX_IDH: v = {1'b1, SOPID_IDH_RSVD[2:0], PART_NUMBER[11:8]};
         SOPID_IDX_IDL: v = PART_NUMBER[7:0];
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // strobe decode
   assign wr_opt1 = i_wr && (i_addr == SOPID_IDX_OPT1);
   assign wr_opt2 = i_wr && (i_addr == SOPID_IDX_OPT2);
   assign wr_svc = i_wr && (i_addr == SOPID_IDX_SVC);

   // window only counts while the watchdog runs on the bus clock
   assign window_on = opt2_reg[SOPID_O2_WIN] && opt2_reg[SOPID_O2_CLKS];
   assign early_hit = window_on && i_wdog_enabled && !i_wdog_late && wr_svc;

   // first option register: the lock closes on the first write
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         opt1_reg <= SOPID_O1_RST;
         opt1_lock_reg <= 1'b0;
      end
      else if (wr_opt1 && !opt1_lock_reg)
      begin
         opt1_reg <= i_wdata & SOPID_O1_MASK;
         opt1_lock_reg <= 1'b1;
      end
   end

   // second option register: clock select and window are once, the rest free
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         opt2_reg <= SOPID_O2_RST;
         opt2_lock_reg <= 1'b0;
      end
      else if (wr_opt2)
      begin
         opt2_lock_reg <= 1'b1;
         if (!opt2_lock_reg)
         begin
            opt2_reg <= i_wdata & (SOPID_O2_ONCE | SOPID_O2_FREE);
         end
         else
         begin
            // pin selects stay writable so software can move pins at will
            opt2_reg <= (opt2_reg & SOPID_O2_ONCE) | (i_wdata & SOPID_O2_FREE);
         end
      end
   end

   // read data, one cycle after the strobe; id reads change nothing
   always_comb
   begin
      rdata_next = read_mux(i_addr, opt1_reg, opt2_reg);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         rdata_reg <= SOPID_RDATA_RST;
      end
      else if (i_rd)
      begin
         rdata_reg <= rdata_next;
      end
      else
      begin
         rdata_reg <= SOPID_RDATA_RST;
      end
   end

   // service sequence tracker and watchdog reset decision
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         svc_reg <= SOPID_SVC_IDLE;
         clear_reg <= 1'b0;
         wreset_reg <= 1'b0;
      end
      else
      begin
         clear_reg <= 1'b0;
         wreset_reg <= 1'b0;
         if (wr_svc)
         begin
            if (early_hit)
            begin
               // an early write kills the sequence outright
               wreset_reg <= 1'b1;
               svc_reg <= SOPID_SVC_IDLE;
            end
            else if (i_wdata == SOPID_SVC_FIRST)
            begin
               svc_reg <= SOPID_SVC_ARMED;
            end
            else if (i_wdata == SOPID_SVC_SECOND)
            begin
               case (svc_reg)
                  SOPID_SVC_ARMED: clear_reg <= 1'b1;
                  SOPID_SVC_IDLE: clear_reg <= 1'b0;
                  default: clear_reg <= 1'b0;
               endcase
               svc_reg <= SOPID_SVC_IDLE;
            end
            else
            begin
               wreset_reg <= i_wdog_enabled;
               svc_reg <= SOPID_SVC_IDLE;
            end
         end
      end
   end

   // stop instruction gate
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         stop_reg <= 1'b0;
         illegal_reg <= 1'b0;
      end
      else
      begin
         stop_reg <= i_stop_req && opt1_reg[SOPID_O1_STOP];
         illegal_reg <= i_stop_req && !opt1_reg[SOPID_O1_STOP];
      end
   end

   // comparator is asynchronous to this clock, so two flops first
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         cmp_meta_reg <= 1'b0;
         cmp_sync_reg <= 1'b0;
         cap_reg <= 1'b0;
      end
      else
      begin
         cmp_meta_reg <= i_cmp_out;
         cmp_sync_reg <= cmp_meta_reg;
         cap_reg <= cmp_sync_reg && opt2_reg[SOPID_O2_CAPR];
      end
   end

   // outputs are wires onto flops, no logic in between
   assign o_rdata = rdata_reg;
   assign o_wdog_cfg.timeout_sel = opt1_reg[SOPID_O1_TOUT_HI:SOPID_O1_TOUT_LO];
   assign o_wdog_cfg.use_bus_clk = opt2_reg[SOPID_O2_CLKS];
   assign o_wdog_cfg.window_on = opt2_reg[SOPID_O2_WIN];
   assign o_wdog_cfg.stop_permit = opt1_reg[SOPID_O1_STOP];
   assign o_route.iic_on_port_b = opt1_reg[SOPID_O1_TWOW];
   assign o_route.tim2_ch1_on_pa7 = opt2_reg[SOPID_O2_T2C1];
   assign o_route.tim2_ch0_on_pa6 = opt2_reg[SOPID_O2_T2C0];
   assign o_route.tim1_ch1_on_pc1 = opt2_reg[SOPID_O2_T1C1];
   assign o_route.tim1_ch0_on_pc0 = opt2_reg[SOPID_O2_T1C0];
   assign o_cap_route_en = opt2_reg[SOPID_O2_CAPR];
   assign o_tim1_ch0_cmp = cap_reg;
   assign o_wdog_clear = clear_reg;
   assign o_wdog_reset = wreset_reg;
   assign o_stop_enter = stop_reg;
   assign o_illegal_reset = illegal_reg;

   // checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   opt1_once_a: assert property (
      (wr_opt1 && opt1_lock_reg) |=> $stable(opt1_reg))
      else $error("locked option one changed");

   tout_take_a: assert property (
      (wr_opt1 && !opt1_lock_reg) |=> (o_wdog_cfg.timeout_sel == $past(i_wdata[7:6])))
      else $error("timeout select not taken");

   stop_gate_a: assert property (
      (i_stop_req && !o_wdog_cfg.stop_permit) |=> (o_illegal_reset && !o_stop_enter))
      else $error("forbidden stop not trapped");

   iic_pins_a: assert property (
      (wr_opt1 && !opt1_lock_reg) |=> (o_route.iic_on_port_b == $past(i_wdata[2])))
      else $error("two wire pin select wrong");

   clks_once_a: assert property (
      (wr_opt2 && opt2_lock_reg) |=> $stable(o_wdog_cfg.use_bus_clk)
         && $stable(o_wdog_cfg.window_on))
      else $error("write once clock select changed");

   window_early_a: assert property (
      (wr_svc && o_wdog_cfg.window_on && o_wdog_cfg.use_bus_clk && i_wdog_enabled
         && !i_wdog_late) |=> (o_wdog_reset && !o_wdog_clear))
      else $error("early service not reset");

   window_slow_a: assert property (
      (wr_svc && !o_wdog_cfg.use_bus_clk && i_wdata == SOPID_SVC_FIRST) |=> !o_wdog_reset)
      else $error("window applied on slow clock");

   cmp_route_a: assert property (
      ##1 o_tim1_ch0_cmp == ($past(cmp_sync_reg) && $past(o_cap_route_en)))
      else $error("comparator route wrong");

   pin_free_a: assert property (
      wr_opt2 |=> ({o_route.tim2_ch1_on_pa7, o_route.tim2_ch0_on_pa6,
         o_route.tim1_ch1_on_pc1, o_route.tim1_ch0_on_pc0} == $past(i_wdata[3:0])))
      else $error("timer pin selects not taken");

   idh_read_a: assert property (
      (i_rd && i_addr == SOPID_IDX_IDH) |=> (o_rdata[7] && o_rdata[3:0] == PART_NUMBER[11:8]))
      else $error("high part number wrong");

   idl_read_a: assert property (
      (i_rd && i_addr == SOPID_IDX_IDL) |=> (o_rdata == PART_NUMBER[7:0]))
      else $error("low part number wrong");

   svc_pair_a: assert property (
      (wr_svc && i_wdata == SOPID_SVC_SECOND && svc_reg == SOPID_SVC_ARMED && !early_hit)
         |=> o_wdog_clear)
      else $error("service pair did not clear");

   svc_bad_a: assert property (
      (wr_svc && i_wdog_enabled && i_wdata != SOPID_SVC_FIRST
         && i_wdata != SOPID_SVC_SECOND) |=> o_wdog_reset)
      else $error("bad service value not reset");

   locks_open_a: assert property (
      !$past(i_rst_n) |-> (!opt1_lock_reg && !opt2_lock_reg))
      else $error("lock survived reset");

   id_quiet_a: assert property (
      (i_rd && !i_wr) |=> ($stable(opt1_reg) && $stable(opt2_reg) && !o_wdog_clear))
      else $error("read had a side effect");

   stop_ok_a: assert property (
      (i_stop_req && o_wdog_cfg.stop_permit) |=> (o_stop_enter && !o_illegal_reset))
      else $error("permitted stop not entered");

   stop_quiet_a: assert property (
      !i_stop_req |=> (!o_stop_enter && !o_illegal_reset))
      else $error("stop pulse without request");

   win_late_a: assert property (
      (wr_svc && window_on && i_wdog_late && i_wdata == SOPID_SVC_FIRST) |=> !o_wdog_reset)
      else $error("late window service reset");

   lone_second_a: assert property (
      (wr_svc && i_wdata == SOPID_SVC_SECOND && svc_reg == SOPID_SVC_IDLE && !early_hit)
         |=> (!o_wdog_clear && !o_wdog_reset))
      else $error("lone second byte acted");

   svc_quiet_a: assert property (
      !wr_svc |=> (!o_wdog_clear && !o_wdog_reset))
      else $error("service pulse without write");

   opt1_unused_a: assert property (
      (i_rd && i_addr == SOPID_IDX_OPT1) |=> ((o_rdata & ~SOPID_O1_MASK) == 8'h00))
      else $error("unused option one bits not zero");

   opt2_unused_a: assert property (
      (i_rd && i_addr == SOPID_IDX_OPT2) |=> !o_rdata[5])
      else $error("unused option two bit not zero");

   rdata_idle_a: assert property (
      !i_rd |=> (o_rdata == SOPID_RDATA_RST))
      else $error("read data outside read cycle");

endmodule

//--- test_sopid_regs.sv
// testbench for the system options and part number register bank
// assumes sopid_pkg and sopid_regs are compiled first; the bench drives every port itself
`timescale 1ns/1ps

module test_sopid_regs;
   import sopid_pkg::*;

   localparam logic [11:0] PART = 12'h3B7; // arbitrary value, differs from the design default
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_wdog_enabled = 1'b0;
   logic i_wdog_late = 1'b0;
   logic i_stop_req = 1'b0;
   logic i_cmp_out = 1'b0;
   logic [7:0] o_rdata;
   sopid_wdog_cfg_t o_wdog_cfg;
   sopid_route_t o_route;
   logic o_cap_route_en, o_tim1_ch0_cmp, o_wdog_clear, o_wdog_reset, o_stop_enter, o_illegal_reset;
   int error_cnt = 0;
   int tests_run = 0;
   int cycles = 0;

   // pulse outputs gathered so one compare covers all four: clear, reset, stop, illegal
   wire logic [7:0] pulses = {4'h0, o_wdog_clear, o_wdog_reset, o_stop_enter, o_illegal_reset};
   wire logic [7:0] cfg = {3'h0, o_wdog_cfg};
   wire logic [7:0] route = {3'h0, o_route};

   sopid_regs #(.PART_NUMBER(PART)) uut (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_wdog_enabled(i_wdog_enabled),
      .i_wdog_late(i_wdog_late), .i_stop_req(i_stop_req), .i_cmp_out(i_cmp_out),
      .o_wdog_cfg(o_wdog_cfg), .o_route(o_route), .o_cap_route_en(o_cap_route_en),
      .o_tim1_ch0_cmp(o_tim1_ch0_cmp), .o_wdog_clear(o_wdog_clear),
      .o_wdog_reset(o_wdog_reset), .o_stop_enter(o_stop_enter),
      .o_illegal_reset(o_illegal_reset));

   // 125 MHz clock
   always #4 i_ref_clk = ~i_ref_clk;

   // hang guard: far above the longest legal run
   always @(posedge i_ref_clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         $display("Error timeout expected end of run seen %0d cycles", cycles);
         error_cnt++;
         complete_run();
      end
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask

   // one-cycle strobes; returns just after the taking edge so pulses are visible
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1;
      chk(what, exp, o_rdata);
   endtask

   task automatic stop_chk(input logic [7:0] exp);
      @(posedge i_ref_clk);
      i_stop_req <= 1'b1;
      @(posedge i_ref_clk);
      i_stop_req <= 1'b0;
      #1;
      chk("stop pulses", exp, pulses);
   endtask

   task automatic set_wd(input logic en, input logic late);
      @(posedge i_ref_clk);
      i_wdog_enabled <= en;
      i_wdog_late <= late;
   endtask

   task automatic do_reset();
      @(posedge i_ref_clk);
      i_rst_n <= 1'b0;
      repeat (8) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      #1;
   endtask

   // reset state of both option registers and their outputs
   task automatic t_reset_state();
      do_reset();
      chk("cfg after reset", 8'h00, cfg);
      chk("route after reset", 8'h00, route);
      rd_chk(SOPID_IDX_OPT1, 8'h00, "opt1 reset");
      rd_chk(SOPID_IDX_OPT2, 8'h00, "opt2 reset");
   endtask

   // first option register takes one write only; stop permit decides stop outcome
   task automatic t_opt1_once();
      wr(SOPID_IDX_OPT1, 8'hFF);
      chk("cfg opt1", 8'h19, cfg);
      chk("route iic", 8'h10, route);
      rd_chk(SOPID_IDX_OPT1, 8'hE4, "opt1 read");
      wr(SOPID_IDX_OPT1, 8'h00);
      rd_chk(SOPID_IDX_OPT1, 8'hE4, "opt1 locked");
      chk("cfg locked", 8'h19, cfg);
      stop_chk(8'h02);
      do_reset();
      wr(SOPID_IDX_OPT1, 8'h40);
      rd_chk(SOPID_IDX_OPT1, 8'h40, "opt1 reopened");
      chk("cfg timeout 01", 8'h08, cfg);
      chk("route iic low", 8'h00, route);
      stop_chk(8'h01);
   endtask

   // second option register: upper bits once, lower bits free, walking one over routes
   task automatic t_opt2();
      do_reset();
      wr(SOPID_IDX_OPT2, 8'hFF);
      rd_chk(SOPID_IDX_OPT2, 8'hDF, "opt2 read");
      chk("cfg clk win", 8'h06, cfg);
      wr(SOPID_IDX_OPT2, 8'h00);
      rd_chk(SOPID_IDX_OPT2, 8'hC0, "opt2 locked");
      for (int i = 0; i < 5; i++)
      begin
         wr(SOPID_IDX_OPT2, 8'h01 << i);
         chk("route walk", (i < 4) ? (8'h01 << i) : 8'h00, route);
         chk("cap route", {7'h00, i == 4}, {7'h00, o_cap_route_en});
      end
      // comparator passes through two sync flops and one output flop
      @(posedge i_ref_clk);
      i_cmp_out <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk("cmp routed", 8'h01, {7'h00, o_tim1_ch0_cmp});
      wr(SOPID_IDX_OPT2, 8'hC0);
      repeat (2) @(posedge i_ref_clk);
      #1;
      chk("cmp open", 8'h00, {7'h00, o_tim1_ch0_cmp});
   endtask

   // part number registers ignore writes and reads leave no trace
   task automatic t_id();
      rd_chk(SOPID_IDX_IDH, {4'h8, PART[11:8]}, "id high");
      wr(SOPID_IDX_IDH, 8'h7F);
      rd_chk(SOPID_IDX_IDH, {4'h8, PART[11:8]}, "id high wr");
      wr(SOPID_IDX_IDL, ~PART[7:0]);
      rd_chk(SOPID_IDX_IDL, PART[7:0], "id low");
      rd_chk(SOPID_IDX_IDL, PART[7:0], "id low again");
      rd_chk(3'h7, 8'h00, "unmapped");
   endtask

   // service sequence in normal mode, then window mode with and without bus clock
   task automatic t_service();
      do_reset();
      set_wd(1'b1, 1'b0);
      wr(SOPID_IDX_SVC, SOPID_SVC_FIRST);
      chk("armed", 8'h00, pulses);
      wr(SOPID_IDX_SVC, SOPID_SVC_SECOND);
      chk("clear", 8'h08, pulses);
      wr(SOPID_IDX_SVC, 8'h12);
      chk("bad value", 8'h04, pulses);
      wr(SOPID_IDX_SVC, SOPID_SVC_SECOND);
      chk("lone second", 8'h00, pulses);
      set_wd(1'b0, 1'b0);
      wr(SOPID_IDX_SVC, 8'h12);
      chk("disabled", 8'h00, pulses);
      do_reset();
      wr(SOPID_IDX_OPT2, 8'hC0);
      set_wd(1'b1, 1'b0);
      wr(SOPID_IDX_SVC, SOPID_SVC_FIRST);
      chk("early window", 8'h04, pulses);
      set_wd(1'b1, 1'b1);
      wr(SOPID_IDX_SVC, SOPID_SVC_FIRST);
      wr(SOPID_IDX_SVC, SOPID_SVC_SECOND);
      chk("late window", 8'h08, pulses);
      do_reset();
      wr(SOPID_IDX_OPT2, 8'h40);
      set_wd(1'b1, 1'b0);
      wr(SOPID_IDX_SVC, SOPID_SVC_FIRST);
      chk("slow clk early", 8'h00, pulses);
      wr(SOPID_IDX_SVC, SOPID_SVC_SECOND);
      chk("slow clk clear", 8'h08, pulses);
   endtask

   task automatic complete_run();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // main sequence
   initial
   begin
      t_reset_state();
      t_opt1_once();
      t_opt2();
      t_id();
      t_service();
      complete_run();
   end
endmodule
